// *** ubt_cfg.svh ***
// offsets, field positions, reset values and counts for the serial channel
`ifndef UBT_CFG_SVH
`define UBT_CFG_SVH
// register offsets on the 3-bit host address
`define UBT_OFS_DATA     3'h0
`define UBT_OFS_IER      3'h1
`define UBT_OFS_FCR      3'h2
`define UBT_OFS_LCR      3'h3
`define UBT_OFS_MCR      3'h4
`define UBT_OFS_LSR      3'h5
`define UBT_OFS_MSR      3'h6
`define UBT_OFS_SPR      3'h7
// key in the line control register that opens the enhanced bank
`define UBT_ENH_KEY      8'hbf
// field positions
`define UBT_FCR_FIFO_EN  0
`define UBT_FCR_TX_RST   2
`define UBT_MCR_PRESCALE 7
`define UBT_EXTENDED_STATUS_CTRL_REG_RATIO   7
`define UBT_FEATURE_CONTROL_REG_DIR     3
`define UBT_LSR_RX_RDY   0
`define UBT_LSR_THR_MT   5
`define UBT_LSR_TX_MT    6
// reset values
`define UBT_RST_DLL      8'h01
`define UBT_RST_DLM      8'h00
`define UBT_RST_REG      8'h00
`define UBT_RST_EXTENDED_STATUS_CTRL_REG     8'h80
// counts
`define UBT_SAMPLES_16X  5'h10
`define UBT_SAMPLES_8X   5'h08
`define UBT_PRESCALE_TOP 2'h3
`define UBT_TX_DEPTH     64
`define UBT_TX_AW        6
// fifo trigger levels, tx then rx, index by the fcr select field
`define UBT_TXTRIG_0     7'h08
`define UBT_TXTRIG_1     7'h10
`define UBT_TXTRIG_2     7'h20
`define UBT_TXTRIG_3     7'h38
`define UBT_RXTRIG_0     7'h08
`define UBT_RXTRIG_1     7'h10
`define UBT_RXTRIG_2     7'h38
`define UBT_RXTRIG_3     7'h3c
`endif

// *** ubt_core.sv ***
// one serial channel: host registers, prescaler, rate generator, transmitter, irq pins
//
// Contract
// - fifo off, normal: tx irq low while holding full, high when empty
// - fifo on, normal: tx irq low above trigger, high below or empty
// - direction mode: tx irq high only at transmitter empty, or below trigger
// - fifo on: rx irq high above rx trigger, low below
// - host access needs no rate clock; one clock serves rate logic; here host pins are synchronised and decoded on core_clk, the rate clock
// - prescaler divides by one or four, chosen by modem control bit 7
// - rate generator divides prescaled clock by 16-bit divisor 1..65535
// - sampling clock times transmit shifting and receive sampling
// - divisor resets to one: low byte 01, high byte 00
// - ratio bit 7 set gives 16 samples per bit, clear gives 8
// - each serial bit lasts 16 or 8 sampling periods
// - 8-bit shift register fed by 64-byte fifo through holding register
// - frame is start, data bits, optional parity, stop bits
// - holding and shifter status appear in line status bits 5 and 6
// - data goes out least significant bit first
// - holding register is write only; reads return no transmit data
// - with fifo on, each holding write pushes and advances write pointer; a write to a full fifo is dropped
// - direction mode off at reset, on only via feature control bit 3
// - fifo mode: holding-empty flag set whenever tx fifo is empty
// - transmitter-empty flag set only when shifter and fifo both empty
`include "ubt_cfg.svh"
module ubt_core (
  input  wire logic              core_clk,       // channel clock
  input  wire logic              reset,          // sync reset, high
  input  wire ubt_pkg::ubt_host_t host_in,       // async host bus pins
  input  wire logic [6:0]        rx_level,       // receive fill, same clock
  output logic [7:0]             data_out,       // read data to bus
  output logic                   data_oe,        // drive bus, high
  output logic                   tx_out,         // serial line
  output logic                   rx_sample_tick, // sample pulse for receiver
  output logic                   irq_tx_chan_a,  // transmit irq level
  output logic                   irq_rx_chan_a,  // receive irq level
  output logic                   irq_out_chan_a  // channel irq pin
);
  import ubt_pkg::*;

  // host pin synchroniser stages and edge history
  ubt_host_t     host_s1_ff;
  ubt_host_t     host_s2_ff;
  ubt_host_t     host_prev_ff;
  // registers
  logic [7:0]    dll_ff;
  logic [7:0]    dlm_ff;
  logic [7:0]    ier_ff;
  logic [7:0]    fcr_ff;
  ubt_lcr_t      lcr_ff;
  logic [7:0]    modem_control_reg_ff;
  logic [7:0]    extended_status_ctrl_reg_ff;
  logic [7:0]    feature_control_reg_ff;
  logic [7:0]    spr_ff;
  // rate logic
  logic [1:0]    pre_cnt_ff;
  logic [15:0]   div_cnt_ff;
  logic          sample_ff;
  // transmitter
  ubt_tx_state_t tx_state_ff;
  ubt_tx_state_t nxt_tx_state;
  logic [7:0]    tx_shift_reg_ff;
  logic [4:0]    samp_cnt_ff;
  logic [2:0]    bit_cnt_ff;
  logic          stop_cnt_ff;
  logic          par_bit_ff;
  // registered outputs
  logic [7:0]    data_out_ff;
  logic          data_oe_ff;
  logic          tx_out_ff;
  logic          irq_tx_ff;
  logic          irq_rx_ff;
  logic          irq_any_ff;

  // bus decode on the synchronised, settled pins
  wire        wr_done   = !host_prev_ff.cs_n && !host_prev_ff.wr_n && host_s2_ff.wr_n;
  wire [2:0]  wr_addr   = host_prev_ff.addr;
  wire [7:0]  wr_data   = host_prev_ff.data;
  wire        rd_act    = !host_s2_ff.cs_n && !host_s2_ff.rd_n;
  wire [2:0]  rd_addr   = host_s2_ff.addr;
  wire        enh_bank  = lcr_ff == `UBT_ENH_KEY;
  wire        wr_sel0   = wr_done && wr_addr == `UBT_OFS_DATA;
  wire        wr_dll    = wr_sel0 && lcr_ff.dlab;
  wire        wr_thr    = wr_sel0 && !lcr_ff.dlab;
  wire        wr_sel1   = wr_done && wr_addr == `UBT_OFS_IER;
  wire        wr_dlm    = wr_sel1 && lcr_ff.dlab;
  wire        wr_ier    = wr_sel1 && !lcr_ff.dlab;
  wire        wr_fcr    = wr_done && wr_addr == `UBT_OFS_FCR && !enh_bank;
  wire        wr_lcr    = wr_done && wr_addr == `UBT_OFS_LCR;
  wire        wr_sel4   = wr_done && wr_addr == `UBT_OFS_MCR;
  wire        wr_mcr    = wr_sel4 && !enh_bank;
  wire        wr_feature_control_reg   = wr_sel4 && enh_bank;
  wire        wr_extended_status_ctrl_reg   = wr_done && wr_addr == `UBT_OFS_LSR && enh_bank;
  wire        wr_spr    = wr_done && wr_addr == `UBT_OFS_SPR;

  // mode bits
  wire        fifo_en   = fcr_ff[`UBT_FCR_FIFO_EN];
  wire        dir_mode  = feature_control_reg_ff[`UBT_FEATURE_CONTROL_REG_DIR];
  wire        x16       = extended_status_ctrl_reg_ff[`UBT_EXTENDED_STATUS_CTRL_REG_RATIO];
  wire        prescale4 = modem_control_reg_ff[`UBT_MCR_PRESCALE];
  // changing fifo enable or asking for a tx reset empties the holding fifo
  wire        tx_flush  = wr_fcr && (wr_data[`UBT_FCR_TX_RST] ||
                          wr_data[`UBT_FCR_FIFO_EN] != fifo_en);

  // transmit fifo wiring
  wire [7:0]  fifo_head;
  wire        fifo_valid;
  wire        fifo_room;
  wire [6:0]  tx_level;
  wire        tx_idle   = tx_state_ff == st_idle;
  wire        fifo_take = tx_idle && fifo_valid;
  // without fifo the holding register is a single slot; extra writes drop
  wire        hold_room = fifo_en ? fifo_room : tx_level == '0;

  // 64-deep holding fifo, its head feeds the shifter
  ubt_fifo #(
    .WIDTH (8),
    .DEPTH (`UBT_TX_DEPTH),
    .AW    (`UBT_TX_AW)
  ) u_tx_fifo (
    .clk       (core_clk),
    .reset     (reset),
    .flush     (tx_flush),
    .in_valid  (wr_thr && hold_room),
    .in_ready  (fifo_room),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (tx_idle),
    .out_data  (fifo_head),
    .level     (tx_level)
  );

  // line status: bit 5 follows the holding store, bit 6 the whole path
  wire        thr_empty = tx_level == '0;
  wire        tx_empty  = thr_empty && tx_idle;
  wire [7:0]  lsr_val   = {1'b0, tx_empty, thr_empty, 4'h0, rx_level != '0};

  // read mux; data offset never returns transmit bytes
  wire [7:0]  isr_val   = {{2{fifo_en}}, 5'h00, !irq_any_ff};
  wire [7:0]  rd_mux    =
    rd_addr == `UBT_OFS_DATA ? (lcr_ff.dlab ? dll_ff : 8'h00) :
    rd_addr == `UBT_OFS_IER  ? (lcr_ff.dlab ? dlm_ff : ier_ff) :
    rd_addr == `UBT_OFS_FCR  ? isr_val :
    rd_addr == `UBT_OFS_LCR  ? lcr_ff :
    rd_addr == `UBT_OFS_MCR  ? (enh_bank ? feature_control_reg_ff : modem_control_reg_ff) :
    rd_addr == `UBT_OFS_LSR  ? (enh_bank ? extended_status_ctrl_reg_ff : lsr_val) :
    rd_addr == `UBT_OFS_SPR  ? spr_ff : 8'h00;

  // pins cross in two flops; only stage two and later are decoded
  always_ff @(posedge core_clk)
  begin
    host_s1_ff   <= host_in;
    host_s2_ff   <= host_s1_ff;
    host_prev_ff <= host_s2_ff;
  end

  // divisor bytes, written on the rising write strobe
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dll_ff <= `UBT_RST_DLL;
      dlm_ff <= `UBT_RST_DLM;
    end
    else
    begin
      if (wr_dll)
        dll_ff <= wr_data;
      if (wr_dlm)
        dlm_ff <= wr_data;
    end
  end

  // control registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ier_ff                 <= `UBT_RST_REG;
      fcr_ff                 <= `UBT_RST_REG;
      lcr_ff                 <= `UBT_RST_REG;
      modem_control_reg_ff   <= `UBT_RST_REG;
      feature_control_reg_ff <= `UBT_RST_REG;
      spr_ff                 <= `UBT_RST_REG;
    end
    else
    begin
      if (wr_ier)
        ier_ff <= wr_data;
      if (wr_fcr)
        fcr_ff <= {wr_data[7:3], 2'b00, wr_data[0]}; // reset bits self clear
      if (wr_lcr)
        lcr_ff <= wr_data;
      if (wr_mcr)
        modem_control_reg_ff <= wr_data;
      if (wr_feature_control_reg)
        feature_control_reg_ff <= wr_data;
      if (wr_spr)
        spr_ff <= wr_data;
    end
  end

  // sample ratio register defaults to 16 samples per bit
  always_ff @(posedge core_clk)
  begin
    if (reset)
      extended_status_ctrl_reg_ff <= `UBT_RST_EXTENDED_STATUS_CTRL_REG;
    else if (wr_extended_status_ctrl_reg)
      extended_status_ctrl_reg_ff <= wr_data;
  end

  // host read: drive while chip select and read strobe are low
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      data_out_ff <= 8'h00;
      data_oe_ff  <= 1'b0;
    end
    else
    begin
      data_out_ff <= rd_mux;
      data_oe_ff  <= rd_act;
    end
  end

  // prescaler and rate generator; divisor 0 acts as 1 rather than stalling
  wire [15:0] divisor   = {dlm_ff, dll_ff};
  wire [15:0] div_top   = divisor == '0 ? 16'h0000 : divisor - 16'h0001;
  wire        pre_tick  = !prescale4 || pre_cnt_ff == `UBT_PRESCALE_TOP;
  wire        div_wrap  = pre_tick && div_cnt_ff >= div_top;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pre_cnt_ff <= 2'h0;
      div_cnt_ff <= 16'h0000;
      sample_ff  <= 1'b0;
    end
    else
    begin
      pre_cnt_ff <= prescale4 ? pre_cnt_ff + 2'h1 : 2'h0;
      if (pre_tick)
        div_cnt_ff <= div_wrap ? 16'h0000 : div_cnt_ff + 16'h0001;
      sample_ff  <= div_wrap;
    end
  end

  // bit timing from the sampling pulse
  wire [4:0]  samp_top  = (x16 ? `UBT_SAMPLES_16X : `UBT_SAMPLES_8X) - 5'h01;
  wire        bit_end   = sample_ff && samp_cnt_ff == samp_top;
  wire [2:0]  last_bit  = 3'(lcr_ff.wlen) + 3'h4;
  wire [7:0]  word_mask = 8'hff >> (2'h3 - lcr_ff.wlen);
  wire        word_par  = ^(fifo_head & word_mask);
  // stick parity sends the inverse of the even select
  wire        par_val   = lcr_ff.stick ? !lcr_ff.even :
                          (lcr_ff.even ? word_par : !word_par);

  // frame sequencing
  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    unique case (tx_state_ff)
      st_idle:
        if (fifo_valid)
          nxt_tx_state = st_start;
      st_start:
        if (bit_end)
          nxt_tx_state = st_data;
      st_data:
        if (bit_end && bit_cnt_ff == last_bit)
          nxt_tx_state = lcr_ff.par_en ? st_par : st_stop;
      st_par:
        if (bit_end)
          nxt_tx_state = st_stop;
      st_stop:
        if (bit_end && (stop_cnt_ff || !lcr_ff.two_stop))
          nxt_tx_state = st_idle;
      default:
        nxt_tx_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      tx_state_ff <= st_idle;
    else
      tx_state_ff <= nxt_tx_state;
  end

  // sample counter restarts at each bit boundary and at load
  always_ff @(posedge core_clk)
  begin
    if (reset || fifo_take || bit_end)
      samp_cnt_ff <= 5'h00;
    else if (sample_ff)
      samp_cnt_ff <= samp_cnt_ff + 5'h01;
  end

  // shift register loads from the fifo head, shifts right per data bit
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tx_shift_reg_ff <= 8'h00;
      par_bit_ff      <= 1'b0;
    end
    else if (fifo_take)
    begin
      tx_shift_reg_ff <= fifo_head;
      par_bit_ff      <= par_val;
    end
    else if (bit_end && tx_state_ff == st_data)
      tx_shift_reg_ff <= {1'b0, tx_shift_reg_ff[7:1]};
  end

  // data bit and stop bit counters
  always_ff @(posedge core_clk)
  begin
    if (reset || tx_idle)
    begin
      bit_cnt_ff  <= 3'h0;
      stop_cnt_ff <= 1'b0;
    end
    else if (bit_end)
    begin
      if (tx_state_ff == st_data)
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (tx_state_ff == st_stop)
        stop_cnt_ff <= 1'b1;
    end
  end

  // serial line level; break holds it low
  wire        line_lvl  = tx_state_ff == st_start ? 1'b0 :
                          tx_state_ff == st_data  ? tx_shift_reg_ff[0] :
                          tx_state_ff == st_par   ? par_bit_ff : 1'b1;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      tx_out_ff <= 1'b1;
    else
      tx_out_ff <= line_lvl && !lcr_ff.brk;
  end

  // trigger levels picked by the fcr select fields
  wire [6:0]  tx_trig   = fcr_ff[5:4] == 2'h0 ? `UBT_TXTRIG_0 :
                          fcr_ff[5:4] == 2'h1 ? `UBT_TXTRIG_1 :
                          fcr_ff[5:4] == 2'h2 ? `UBT_TXTRIG_2 : `UBT_TXTRIG_3;
  wire [6:0]  rx_trig   = fcr_ff[7:6] == 2'h0 ? `UBT_RXTRIG_0 :
                          fcr_ff[7:6] == 2'h1 ? `UBT_RXTRIG_1 :
                          fcr_ff[7:6] == 2'h2 ? `UBT_RXTRIG_2 : `UBT_RXTRIG_3;
  wire        tx_above  = tx_level > tx_trig;

  // irq levels; high means service wanted
  wire        tx_irq_n  = fifo_en ? !tx_above : thr_empty;
  wire        tx_irq_d  = fifo_en ? (!tx_above || tx_empty) : tx_empty;
  wire        tx_irq    = dir_mode ? tx_irq_d : tx_irq_n;
  wire        rx_irq    = fifo_en ? rx_level > rx_trig : rx_level != '0;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_tx_ff  <= 1'b1;
      irq_rx_ff  <= 1'b0;
      irq_any_ff <= 1'b1;
    end
    else
    begin
      irq_tx_ff  <= tx_irq;
      irq_rx_ff  <= rx_irq;
      irq_any_ff <= tx_irq || rx_irq;
    end
  end

  assign data_out       = data_out_ff;
  assign data_oe        = data_oe_ff;
  assign tx_out         = tx_out_ff;
  assign rx_sample_tick = sample_ff;
  assign irq_tx_chan_a  = irq_tx_ff;
  assign irq_rx_chan_a  = irq_rx_ff;
  assign irq_out_chan_a = irq_any_ff;
endmodule

// *** ubt_core_sva.sv ***
// port assertions for the serial channel
module ubt_core_sva (
  input wire logic               core_clk,       // channel clock
  input wire logic               reset,          // sync reset, high
  input wire ubt_pkg::ubt_host_t host_in,        // host bus pins
  input wire logic [6:0]         rx_level,       // receive fill
  input wire logic [7:0]         data_out,       // read data
  input wire logic               data_oe,        // bus drive
  input wire logic               tx_out,         // serial line
  input wire logic               rx_sample_tick, // sample pulse
  input wire logic               irq_tx_chan_a,  // transmit irq
  input wire logic               irq_rx_chan_a,  // receive irq
  input wire logic               irq_out_chan_a  // channel irq pin
);
  import ubt_pkg::*;
  logic rd_sel;
  logic irq_any;

  // read strobe as seen at the pins; irq sources combined
  assign rd_sel = !host_in.cs_n && !host_in.rd_n;
  assign irq_any = irq_tx_chan_a || irq_rx_chan_a;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);

  reset_levels_a: assert property ($fell(reset) |-> tx_out && !data_oe && irq_tx_chan_a && !irq_rx_chan_a)
    else $error("outputs not at reset level");
  drive_on_read_a: assert property (data_oe |-> $past(rd_sel, 3) || $past(rd_sel, 4) || $past(rd_sel, 5))
    else $error("bus driven without a read");
  drive_release_a: assert property (!rd_sel [*6] |-> !data_oe)
    else $error("bus still driven after read");
  unmapped_zero_a: assert property (data_oe && $past(host_in.addr, 3) == 3'h6 |-> data_out == 8'h00)
    else $error("unmapped read not zero");
  start_len_a: assert property ($fell(tx_out) |=> !tx_out [*6])
    else $error("low bit too short");
  high_len_a: assert property ($rose(tx_out) |=> tx_out [*7])
    else $error("high bit too short");
  rx_none_a: assert property (rx_level == 7'h00 [*2] |-> !irq_rx_chan_a)
    else $error("rx irq with no data");
  rx_full_a: assert property (rx_level > 7'h3c [*2] |-> irq_rx_chan_a)
    else $error("rx irq missing above trigger");
  irq_pin_hi_a: assert property (irq_any && $past(irq_any) |-> irq_out_chan_a)
    else $error("irq pin low with source high");
  irq_pin_lo_a: assert property (!irq_any && !$past(irq_any) |-> !irq_out_chan_a)
    else $error("irq pin high with no source");
endmodule

bind ubt_core ubt_core_sva u_sva (.core_clk(core_clk), .reset(reset), .host_in(host_in),
  .rx_level(rx_level), .data_out(data_out), .data_oe(data_oe), .tx_out(tx_out),
  .rx_sample_tick(rx_sample_tick), .irq_tx_chan_a(irq_tx_chan_a),
  .irq_rx_chan_a(irq_rx_chan_a), .irq_out_chan_a(irq_out_chan_a));

// *** ubt_core_tb.sv ***
// self-checking bench for the serial channel
`include "ubt_cfg.svh"
module ubt_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ubt_pkg::*;
  logic        core_clk;
  logic        reset;
  ubt_host_t   host;
  logic [6:0]  rx_level;
  logic [7:0]  data_out;
  logic        data_oe, tx_out, tick, irq_tx, irq_rx, irq_out;
  logic [7:0]  bit_clks;
  logic [3:0]  n_bits;
  logic [10:0] word;
  logic        got, g0;
  int          errors, n_compared, per;

  ubt_core u_dut (.core_clk(core_clk), .reset(reset), .host_in(host), .rx_level(rx_level),
    .data_out(data_out), .data_oe(data_oe), .tx_out(tx_out), .rx_sample_tick(tick),
    .irq_tx_chan_a(irq_tx), .irq_rx_chan_a(irq_rx), .irq_out_chan_a(irq_out));
  ubt_line_model u_line (.core_clk(core_clk), .line(tx_out), .bit_clks(bit_clks),
    .n_bits(n_bits), .word(word), .got(got));

  // 10 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic results();
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // pins are sampled through sync flops, so each phase lasts several edges
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    host.cs_n = 1'b0;
    host.wr_n = 1'b0;
    host.addr = a;
    host.data = d;
    repeat (3) @(negedge core_clk);
    host.wr_n = 1'b1;
    repeat (4) @(negedge core_clk);
    host.cs_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic bus_rd(input logic [2:0] a, input logic [7:0] exp);
    int n;
    host.cs_n = 1'b0;
    host.rd_n = 1'b0;
    host.addr = a;
    n = 0;
    while (data_oe !== 1'b1 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    check(data_oe, 1'b1);
    check(data_out, exp);
    host.rd_n = 1'b1;
    host.cs_n = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask

  task automatic wait_frame(input logic [10:0] exp);
    int n;
    logic g;
    g = got;
    n = 0;
    while (got === g && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    check(word, exp);
    check(11'(got !== g), 11'h001);
  endtask

  task automatic rx_chk(input logic [6:0] lvl, input logic exp);
    rx_level = lvl;
    repeat (3) @(negedge core_clk);
    check(irq_rx, exp);
  endtask

  // ratio and direction need the enhanced bank, the divisor needs lcr bit 7
  task automatic cfg(input logic [7:0] lcr, modem_control_reg, extended_status_ctrl_reg, feature_control_reg, dll);
    bus_wr(`UBT_OFS_LCR, `UBT_ENH_KEY);
    bus_wr(`UBT_OFS_LSR, extended_status_ctrl_reg);
    bus_wr(`UBT_OFS_MCR, feature_control_reg);
    bus_wr(`UBT_OFS_LCR, 8'h80);
    bus_wr(`UBT_OFS_DATA, dll);
    bus_wr(`UBT_OFS_IER, 8'h00);
    bus_wr(`UBT_OFS_LCR, lcr);
    bus_wr(`UBT_OFS_MCR, modem_control_reg);
    per = dll * (modem_control_reg[7] ? 4 : 1);
    bit_clks = 8'(per * (extended_status_ctrl_reg[7] ? 16 : 8));
    n_bits = lcr[3] ? 4'ha : 4'h9;
  endtask

  task automatic frame(input logic [7:0] lcr, modem_control_reg, extended_status_ctrl_reg, feature_control_reg, dll, d, input logic irq_mid);
    int t;
    logic [10:0] w;
    cfg(lcr, modem_control_reg, extended_status_ctrl_reg, feature_control_reg, dll);
    w = lcr[3] ? {1'b1, ~^d, d} : {2'b01, d};
    t = 0;
    bus_wr(`UBT_OFS_DATA, d);
    repeat (64)
    begin
      @(negedge core_clk);
      t += tick;
    end
    check(11'(t), 11'(64 / per));
    check(irq_tx, irq_mid);
    bus_rd(`UBT_OFS_LSR, 8'h20);
    wait_frame(w);
    repeat (bit_clks) @(negedge core_clk);
    check(irq_tx, 1'b1);
    bus_rd(`UBT_OFS_LSR, 8'h60);
  endtask

  // hang guard, well past the longest drain
  initial
  begin
    repeat (95000) @(posedge core_clk);
    errors++;
    results();
  end

  // reset, then registers, frames, fifo and irq levels
  initial
  begin
    reset = 1'b1;
    host = 14'h3800;
    rx_level = 7'h00;
    bit_clks = 8'h20;
    n_bits = 4'h9;
    errors = 0;
    n_compared = 0;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    bus_wr(`UBT_OFS_LCR, 8'h80);
    bus_rd(`UBT_OFS_DATA, 8'h01);
    bus_rd(`UBT_OFS_IER, 8'h00);
    bus_wr(`UBT_OFS_IER, 8'h12);
    bus_wr(`UBT_OFS_DATA, 8'h34);
    bus_rd(`UBT_OFS_IER, 8'h12);
    bus_rd(`UBT_OFS_DATA, 8'h34);
    bus_wr(`UBT_OFS_LCR, `UBT_ENH_KEY);
    bus_rd(`UBT_OFS_LSR, 8'h80);
    bus_wr(`UBT_OFS_LCR, 8'h03);
    bus_rd(`UBT_OFS_LSR, 8'h60);
    bus_rd(`UBT_OFS_DATA, 8'h00);
    bus_rd(`UBT_OFS_MSR, 8'h00);
    frame(8'h03, 8'h00, 8'h80, 8'h00, 8'h02, 8'ha5, 1'b1);
    frame(8'h0b, 8'h00, 8'h00, 8'h00, 8'h02, 8'h3c, 1'b1);
    frame(8'h03, 8'h80, 8'h80, 8'h00, 8'h01, 8'h81, 1'b1);
    // slow line so the fifo fills past full before the first frame ends
    cfg(8'h03, 8'h80, 8'h00, 8'h00, 8'h03);
    bus_wr(`UBT_OFS_FCR, 8'h01);
    for (int i = 0; i < 66; i++)
      bus_wr(`UBT_OFS_DATA, 8'(i));
    check(irq_tx, 1'b0);
    check(irq_out, 1'b0);
    bus_rd(`UBT_OFS_LSR, 8'h00);
    for (int i = 0; i < 65; i++)
      wait_frame({3'h1, 8'(i)});
    // the 66th byte met a full fifo, so no further frame may follow
    g0 = got;
    repeat (2000) @(negedge core_clk);
    check(11'(got), 11'(g0));
    check(irq_tx, 1'b1);
    bus_rd(`UBT_OFS_LSR, 8'h60);
    rx_chk(7'h08, 1'b0);
    rx_chk(7'h09, 1'b1);
    rx_chk(7'h40, 1'b1);
    bus_wr(`UBT_OFS_FCR, 8'h00);
    rx_chk(7'h01, 1'b1);
    rx_chk(7'h00, 1'b0);
    frame(8'h03, 8'h00, 8'h80, 8'h08, 8'h02, 8'h5a, 1'b0);
    results();
  end
endmodule

// *** ubt_fifo.sv ***
// synchronous fifo with valid and ready on both sides
module ubt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             clk,       // clock
  input  wire logic             reset,     // sync reset, high
  input  wire logic             flush,     // empties the fifo
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // reader takes word
  output logic [WIDTH-1:0]      out_data,  // head word
  output logic [AW:0]           level      // words held
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  wire              push;
  wire              pop;

  // handshake terms; a full fifo refuses, the writer sees in_ready low
  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_ff];
  assign level     = cnt_ff;
  assign nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  // storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge clk)
  begin
    if (reset || flush)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      cnt_ff    <= nxt_cnt;
    end
  end
endmodule

// *** ubt_line_model.sv ***
// remote serial receiver that samples the channel transmit line
module ubt_line_model (
  input  wire logic        core_clk, // channel clock
  input  wire logic        line,     // serial line from the channel
  input  wire logic [7:0]  bit_clks, // clocks per serial bit
  input  wire logic [3:0]  n_bits,   // bits kept after the start bit
  output logic      [10:0] word,     // bits seen, first one at lsb
  output logic             got       // toggles once per frame
);
  timeunit 1ns;
  timeprecision 1ns;

  // hunt the start edge, then sample each bit in its middle
  initial
  begin
    got = 1'b0;
    word = 11'h000;
    forever
    begin
      @(negedge line);
      word = 11'h000;
      repeat (bit_clks / 2) @(posedge core_clk);
      for (int i = 0; i < n_bits; i++)
      begin
        repeat (bit_clks) @(posedge core_clk);
        word[i] = line;
      end
      got = ~got;
    end
  end
endmodule

// *** ubt_pkg.sv ***
// types shared by the serial channel files
package ubt_pkg;
  // host bus pins as they arrive, all asynchronous
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } ubt_host_t;

  // line control fields
  typedef struct packed {
    logic       dlab;
    logic       brk;
    logic       stick;
    logic       even;
    logic       par_en;
    logic       two_stop;
    logic [1:0] wlen;
  } ubt_lcr_t;

  // transmitter states
  typedef enum logic [4:0] {
    st_idle  = 5'h01,
    st_start = 5'h02,
    st_data  = 5'h04,
    st_par   = 5'h08,
    st_stop  = 5'h10
  } ubt_tx_state_t;
endpackage
